// File: hdl/bdpr_parity_report.sv
// data parity reporting logic of the bridge, both bus interfaces
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "bdpr_defines.svh"
module bdpr_parity_report import bdpr_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // data phases seen on the two buses
  input wire bdpr_phase_t pri_phase,
  input wire bdpr_phase_t sec_phase,
  // primary error pin, three-state
  output logic primary_parity_error_n,
  output logic primary_parity_error_oe,
  // secondary error pin, three-state
  output logic secondary_parity_error_n,
  output logic secondary_parity_error_oe,
  // interrupt
  output logic irq
);

  //==========================================================
  // helpers
  // pin sequence: drive low one clock, drive high one clock, release
  function automatic bdpr_pin_t pin_step(input bdpr_pin_t cur, input logic fire);
    bdpr_pin_t nxt;
    nxt = BDPR_IDLE;
    case (cur)
      BDPR_DRIVE: nxt = BDPR_PARK;
      default: nxt = BDPR_IDLE;
    endcase
    if (fire) begin
      nxt = BDPR_DRIVE;
    end
    return nxt;
  endfunction

  // bridge is write target or read initiator on a bus
  function automatic logic may_drive(input bdpr_phase_t ph);
    return ph.active & ((~ph.master & ph.write) | (ph.master & ~ph.write));
  endfunction

  //==========================================================
  // state
  logic [1:0] ctrl_reg;
  logic [1:0] status_reg;
  logic [1:0] mask_reg;
  logic fwd_p_reg;
  logic fwd_s_reg;
  bdpr_pin_t ppin_reg;
  bdpr_pin_t spin_reg;

  //==========================================================
  // apb decode
  wire acc = psel & penable;
  wire done = acc & pready;
  wire hit_ctrl = paddr == `BDPR_CTRL_OFF;
  wire hit_stat = paddr == `BDPR_STAT_OFF;
  wire hit_mask = paddr == `BDPR_MASK_OFF;
  wire hit_pend = paddr == `BDPR_PEND_OFF;
  wire hit_any = hit_ctrl | hit_stat | hit_mask | hit_pend;
  wire wr = done & pwrite;
  wire [1:0] clr_w = (wr & hit_stat) ? pwdata[1:0] : 2'h0;
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    if (hit_ctrl) begin
      rd_mux = {30'h0, ctrl_reg};
    end else if (hit_stat) begin
      rd_mux = {30'h0, status_reg};
    end else if (hit_mask) begin
      rd_mux = {30'h0, mask_reg};
    end else if (hit_pend) begin
      rd_mux = {30'h0, fwd_s_reg, fwd_p_reg};
    end
  end

  wire en_p = ctrl_reg[`BDPR_PRI_BIT];
  wire en_s = ctrl_reg[`BDPR_SEC_BIT];

  //==========================================================
  // master data parity detected events
  wire p_err = pri_phase.bad_par | ~pri_phase.perr_n;
  wire s_err = sec_phase.bad_par | ~sec_phase.perr_n;
  wire p_set = pri_phase.active & pri_phase.master & en_p & p_err;
  wire s_set = sec_phase.active & sec_phase.master & en_s & s_err;
  wire [1:0] set_w = {s_set, p_set};
  // set wins over a write-one clear in the same cycle
  wire [1:0] status_next = (status_reg & ~clr_w) | set_w;
  wire [1:0] mask_next = (wr & hit_mask) ? pwdata[1:0] : mask_reg;
  // interrupt follows the next state so it rises with the status bit, not a cycle later
  wire irq_next = |(status_next & mask_next);

  //==========================================================
  // delayed write error forwarding
  // target reported error while bridge completed a delayed write as master
  wire p_cap = sec_phase.active & sec_phase.master & sec_phase.write & sec_phase.delayed & sec_phase.down &
               ~sec_phase.perr_n & ~sec_phase.fwd;
  wire s_cap = pri_phase.active & pri_phase.master & pri_phase.write & pri_phase.delayed & ~pri_phase.down &
               ~pri_phase.perr_n & ~pri_phase.fwd;
  // initiator retries and completes the delayed write on its own bus
  wire p_done_dw = pri_phase.active & ~pri_phase.master & pri_phase.write & pri_phase.delayed & pri_phase.down;
  wire s_done_dw = sec_phase.active & ~sec_phase.master & sec_phase.write & sec_phase.delayed & ~sec_phase.down;
  wire p_fwd_hit = p_done_dw & fwd_p_reg & en_p & en_s;
  wire s_fwd_hit = s_done_dw & fwd_s_reg & en_p & en_s;
  // a pending error survives until the completion that carries it
  wire fwd_p_next = p_cap | (fwd_p_reg & ~p_done_dw);
  wire fwd_s_next = s_cap | (fwd_s_reg & ~s_done_dw);

  //==========================================================
  // error pin triggers
  // only the side that receives the data may report it, so the role gates every cause
  wire p_role = may_drive(pri_phase);
  wire s_role = may_drive(sec_phase);
  wire p_fire = (p_role & pri_phase.bad_par & en_p) | p_fwd_hit;
  wire s_fire = (s_role & sec_phase.bad_par & en_s) | s_fwd_hit;
  wire bdpr_pin_t ppin_next = pin_step(ppin_reg, p_fire);
  wire bdpr_pin_t spin_next = pin_step(spin_reg, s_fire);
  // pin levels decoded from the next sequencer state, so each pin leaves a flop directly
  wire p_n_next = ppin_next != BDPR_DRIVE;
  wire p_oe_next = ppin_next != BDPR_IDLE;
  wire s_n_next = spin_next != BDPR_DRIVE;
  wire s_oe_next = spin_next != BDPR_IDLE;

  //==========================================================
  // apb answer: one wait state, then registered data
  // the fixed wait keeps the read mux off the output path at the cost of one cycle per access
  wire answer = acc & ~pready;
  wire ready_next = answer;
  wire slverr_next = answer & ~hit_any;
  // read data is zero outside the answer cycle so a stale word never lingers on the bus
  wire [31:0] rdata_next = (answer & ~pwrite) ? rd_mux : 32'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= ready_next;
      pslverr <= slverr_next;
      prdata <= rdata_next;
    end
  end

  // control, status and mask registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `BDPR_CTRL_RST;
      status_reg <= `BDPR_STAT_RST;
      mask_reg <= `BDPR_MASK_RST;
      irq <= 1'b0;
    end else begin
      if (wr & hit_ctrl) begin
        ctrl_reg <= pwdata[1:0];
      end
      status_reg <= status_next;
      mask_reg <= mask_next;
      irq <= irq_next;
    end
  end

  // forwarding flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_p_reg <= 1'b0;
      fwd_s_reg <= 1'b0;
    end else begin
      fwd_p_reg <= fwd_p_next;
      fwd_s_reg <= fwd_s_next;
    end
  end

  // pins: low while driving, high one clock before release so the bus parks high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ppin_reg <= BDPR_IDLE;
      spin_reg <= BDPR_IDLE;
      primary_parity_error_n <= 1'b1;
      primary_parity_error_oe <= 1'b0;
      secondary_parity_error_n <= 1'b1;
      secondary_parity_error_oe <= 1'b0;
    end else begin
      ppin_reg <= ppin_next;
      spin_reg <= spin_next;
      primary_parity_error_n <= p_n_next;
      primary_parity_error_oe <= p_oe_next;
      secondary_parity_error_n <= s_n_next;
      secondary_parity_error_oe <= s_oe_next;
    end
  end

  //==========================================================
  // assertions
  a_pdet_set: assert property (@(posedge pclk) disable iff (!presetn)
    p_set |=> status_reg[0]) else $error("primary master parity bit not set");

  a_sdet_set: assert property (@(posedge pclk) disable iff (!presetn)
    s_set |=> status_reg[1]) else $error("secondary master parity bit not set");

  a_sdet_cause: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(status_reg[1]) |-> $past(s_set)) else $error("secondary bit set without cause");

  a_sdet_enable: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(status_reg[1]) |-> $past(en_s)) else $error("secondary bit set while disabled");

  a_stat_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    status_reg[0] & ~clr_w[0] |=> status_reg[0]) else $error("status bit lost without clear");

  a_pperr_fire: assert property (@(posedge pclk) disable iff (!presetn)
    p_fire |=> !primary_parity_error_n && primary_parity_error_oe) else $error("primary pin not driven low");

  a_pperr_enable: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(primary_parity_error_n) |-> $past(en_p)) else $error("primary pin driven while disabled");

  a_pperr_release: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(primary_parity_error_oe) |-> $past(primary_parity_error_n)) else $error("primary pin released low");

  a_sperr_fire: assert property (@(posedge pclk) disable iff (!presetn)
    s_fire |=> !secondary_parity_error_n && secondary_parity_error_oe) else $error("secondary pin not driven low");

  a_sperr_enable: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(secondary_parity_error_n) |-> $past(en_s)) else $error("secondary pin driven while disabled");

  a_fwd_pri: assert property (@(posedge pclk) disable iff (!presetn)
    p_fwd_hit |=> !primary_parity_error_n ##1 (primary_parity_error_n || $past(p_fire))) else $error("forward not shown");

  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    irq == |(status_reg & mask_reg)) else $error("interrupt level wrong");

  //==========================================================
  // apb answer checks
  a_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready |=> pready) else $error("access not answered after one wait");

  a_apb_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready) else $error("ready held past one cycle");

  a_apb_slverr: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready) else $error("error shown without ready");

  a_rdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == 32'h0) else $error("read data outside answer cycle");

  a_hole_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr && !hit_any |=> $stable(ctrl_reg) && $stable(mask_reg)) else $error("write to hole changed a register");

  //==========================================================
  // status and forwarding checks
  a_pdet_cause: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(status_reg[`BDPR_PRI_BIT]) |-> $past(p_set)) else $error("primary bit set without cause");

  a_pdet_role: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(status_reg[`BDPR_PRI_BIT]) |-> $past(en_p && pri_phase.master))
    else $error("primary bit set outside master role");

  a_sdet_master: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(status_reg[`BDPR_SEC_BIT]) |-> $past(sec_phase.active && sec_phase.master))
    else $error("secondary bit set outside master role");

  a_pdet_clear: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(status_reg[`BDPR_PRI_BIT]) |-> $past(clr_w[`BDPR_PRI_BIT])) else $error("primary bit lost without clear");

  a_sdet_clear: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(status_reg[`BDPR_SEC_BIT]) |-> $past(clr_w[`BDPR_SEC_BIT]))
    else $error("secondary bit lost without clear");

  a_fwd_guard: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(fwd_p_reg) |-> $past(sec_phase.active && !sec_phase.fwd)) else $error("forward armed for known error");

  a_fwd_hold: assert property (@(posedge pclk) disable iff (!presetn)
    fwd_p_reg && !p_done_dw |=> fwd_p_reg) else $error("pending forward lost");

  //==========================================================
  // error pin checks
  a_pperr_role: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(primary_parity_error_n) |-> $past(p_role)) else $error("primary pin driven outside its role");

  a_sperr_role: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(secondary_parity_error_n) |-> $past(s_role)) else $error("secondary pin driven outside its role");

  a_sperr_release: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(secondary_parity_error_oe) |-> $past(secondary_parity_error_n)) else $error("secondary pin released low");

  a_pperr_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    !primary_parity_error_n |=> primary_parity_error_n || $past(p_fire)) else $error("primary pin low too long");

  a_sperr_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    !secondary_parity_error_n |=> secondary_parity_error_n || $past(s_fire)) else $error("secondary pin low too long");

  a_pperr_oe: assert property (@(posedge pclk) disable iff (!presetn)
    !primary_parity_error_n |-> primary_parity_error_oe) else $error("primary pin low while released");

  a_sperr_oe: assert property (@(posedge pclk) disable iff (!presetn)
    !secondary_parity_error_n |-> secondary_parity_error_oe) else $error("secondary pin low while released");

  a_fwd_sec: assert property (@(posedge pclk) disable iff (!presetn)
    s_fwd_hit |=> !secondary_parity_error_n ##1 (secondary_parity_error_n || $past(s_fire)))
    else $error("forward to secondary not shown");

endmodule

// File: inc/bdpr_defines.svh
// constants for the bridge data parity reporting block
//==========================================================
`ifndef BDPR_DEFINES_SVH
`define BDPR_DEFINES_SVH
//==========================================================
// register offsets
`define BDPR_CTRL_OFF 12'h000
`define BDPR_STAT_OFF 12'h004
`define BDPR_MASK_OFF 12'h008
`define BDPR_PEND_OFF 12'h00C
//==========================================================
// field positions
`define BDPR_PRI_BIT 0
`define BDPR_SEC_BIT 1
//==========================================================
// reset values
`define BDPR_CTRL_RST 2'h0
`define BDPR_STAT_RST 2'h0
`define BDPR_MASK_RST 2'h0
`endif

// File: inc/bdpr_pkg.sv
// types for the bridge data parity reporting block
package bdpr_pkg;
  //==========================================================
  // one data phase seen on one bus, with its parity outcome
  typedef struct packed {
    logic active;   // data phase completed this cycle
    logic master;   // bridge is initiator on this bus
    logic write;    // 1 write, 0 read
    logic delayed;  // write is delayed, not posted
    logic down;     // transaction moves downstream
    logic bad_par;  // bridge found bad data parity
    logic perr_n;   // sensed level of the bus error pin
    logic fwd;      // bad parity already came from the initiating bus
  } bdpr_phase_t;
  //==========================================================
  // error pin sequencer
  typedef enum logic [1:0] {
    BDPR_IDLE = 2'b00,
    BDPR_DRIVE = 2'b01,
    BDPR_PARK = 2'b10
  } bdpr_pin_t;
endpackage

// File: verification/bdpr_bus_agent.sv
// bus agent model: presents data phases and resolves an error pin
`timescale 1ns/1ps
module bdpr_bus_agent import bdpr_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // phase request from the bench
  input wire bdpr_phase_t req,
  input wire logic fire,
  // error pin of the bridge
  input wire logic pin_n,
  input wire logic pin_oe,
  // towards the bridge and the bench
  output bdpr_phase_t phase,
  output logic pin_level
);
  //==========================================================
  // phase model
  // one-cycle phase; idle fields scrambled so stale values never help
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= '0;
    end else if (fire) begin
      phase <= req;
    end else begin
      phase <= {1'h0, ~phase[6:0]};
    end
  end
  // pull-up holds the released pin high
  assign pin_level = pin_oe ? pin_n : 1'h1;
endmodule

// File: verification/testbench.sv
// self-checking bench of the bridge data parity reporting block
`timescale 1ns/1ps
`include "bdpr_defines.svh"
module testbench import bdpr_pkg::*;;
  //==========================================================
  // stimulus and observed signals
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq, err, p_n, p_oe, s_n, s_oe, p_lvl, s_lvl;
  logic [1:0] fire = 2'h0;
  bdpr_phase_t req = '0;
  bdpr_phase_t pri_phase, sec_phase;
  int bad_count = 0;
  int total_checks = 0;
  // row: bus, ctrl, phase, pin fires, status after
  logic [13:0] rows [12];

  // 200 MHz clock
  initial begin
    forever #2.5 pclk = ~pclk;
  end

  bdpr_parity_report i_bdpr_parity_report (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pri_phase(pri_phase), .sec_phase(sec_phase), .primary_parity_error_n(p_n),
    .primary_parity_error_oe(p_oe), .secondary_parity_error_n(s_n), .secondary_parity_error_oe(s_oe), .irq(irq));
  bdpr_bus_agent i_bdpr_bus_agent_pri (.pclk(pclk), .presetn(presetn), .req(req), .fire(fire[0]),
    .pin_n(p_n), .pin_oe(p_oe), .phase(pri_phase), .pin_level(p_lvl));
  bdpr_bus_agent i_bdpr_bus_agent_sec (.pclk(pclk), .presetn(presetn), .req(req), .fire(fire[1]),
    .pin_n(s_n), .pin_oe(s_oe), .phase(sec_phase), .pin_level(s_lvl));

  //==========================================================
  // shared tasks
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // apb transfer; held until pready is sampled high, bounded wait
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
      output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    if (n == 20) begin
      bad_count++;
      end_of_test();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d, rd, err);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0, rd, err);
    chk(rd, exp);
  endtask

  // one data phase, then the three-cycle pin sequence of each bus
  task automatic shot(input logic b, input logic [7:0] ph, input logic ep, input logic es);
    @(posedge pclk);
    req <= ph;
    fire[b] <= 1'h1;
    @(posedge pclk);
    fire <= 2'h0;
    @(posedge pclk);
    #1;
    chk({28'h0, p_lvl, p_oe, s_lvl, s_oe}, {28'h0, ~ep, ep, ~es, es});
    @(posedge pclk);
    #1;
    chk({28'h0, p_lvl, s_lvl, p_oe, s_oe}, {28'h0, 2'h3, ep, es});
    @(posedge pclk);
    #1;
    chk({30'h0, p_oe, s_oe}, 32'h0);
  endtask

  //==========================================================
  // main sequence
  initial begin
    rows = '{
      {1'h0, 2'h3, 8'hC6, 1'h1, 2'h1},
      {1'h0, 2'h3, 8'hAE, 1'h1, 2'h0},
      {1'h0, 2'h3, 8'h86, 1'h0, 2'h0},
      {1'h0, 2'h3, 8'hE0, 1'h0, 2'h1},
      {1'h0, 2'h2, 8'hC6, 1'h0, 2'h0},
      {1'h0, 2'h1, 8'hAE, 1'h1, 2'h0},
      {1'h1, 2'h3, 8'hCE, 1'h1, 2'h2},
      {1'h1, 2'h3, 8'hA6, 1'h1, 2'h0},
      {1'h1, 2'h3, 8'hE8, 1'h0, 2'h2},
      {1'h1, 2'h3, 8'h86, 1'h0, 2'h0},
      {1'h1, 2'h1, 8'hCE, 1'h0, 2'h0},
      {1'h1, 2'h2, 8'hCE, 1'h1, 2'h2}};
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    chk({29'h0, p_oe, s_oe, irq}, 32'h0);
    rchk(`BDPR_CTRL_OFF, 32'h0);
    rchk(`BDPR_STAT_OFF, 32'h0);
    rchk(`BDPR_MASK_OFF, 32'h0);
    apb(1'h0, 12'hFF0, 32'h0, rd, err);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // a write to a hole answers with an error and leaves the registers alone
    wr(12'hFF4, 32'h3);
    chk({31'h0, err}, 32'h1);
    rchk(`BDPR_CTRL_OFF, 32'h0);
    foreach (rows[i]) begin
      wr(`BDPR_CTRL_OFF, {30'h0, rows[i][12:11]});
      shot(rows[i][13], rows[i][10:3], rows[i][2] & ~rows[i][13], rows[i][2] & rows[i][13]);
      rchk(`BDPR_STAT_OFF, {30'h0, rows[i][1:0]});
      wr(`BDPR_STAT_OFF, 32'h3);
    end
    // forwarding across the bridge, with and without an earlier error
    wr(`BDPR_CTRL_OFF, 32'h3);
    shot(1'h1, 8'hF8, 1'h0, 1'h0);
    rchk(`BDPR_PEND_OFF, 32'h1);
    shot(1'h0, 8'hBA, 1'h1, 1'h0);
    rchk(`BDPR_PEND_OFF, 32'h0);
    shot(1'h1, 8'hF9, 1'h0, 1'h0);
    shot(1'h0, 8'hBA, 1'h0, 1'h0);
    shot(1'h0, 8'hF0, 1'h0, 1'h0);
    shot(1'h1, 8'hB2, 1'h0, 1'h1);
    // sticky bits, mask and interrupt
    wr(`BDPR_STAT_OFF, 32'h0);
    rchk(`BDPR_STAT_OFF, 32'h3);
    wr(`BDPR_MASK_OFF, 32'h2);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    wr(`BDPR_STAT_OFF, 32'h2);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    rchk(`BDPR_STAT_OFF, 32'h1);
    // reset in mid-run wipes the status
    @(posedge pclk);
    presetn <= 1'h0;
    @(posedge pclk);
    presetn <= 1'h1;
    rchk(`BDPR_STAT_OFF, 32'h0);
    end_of_test();
  end
endmodule
